// *** inc/instruction_word_decode_pkg.sv ***
package instruction_word_decode_pkg;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_W      = 14;
   localparam int CLASS_HI    = 13;
   localparam int CLASS_LO    = 12;
   localparam int OP_HI       = 11;
   localparam int OP_LO       = 8;
   localparam int DEST_POS    = 7;
   localparam int FADDR_HI    = 6;
   localparam int BIT_HI      = 9;
   localparam int BIT_LO      = 7;
   localparam int LIT8_HI     = 7;
   localparam int LIT11_HI    = 10;
   localparam int FADDR_W     = 7;
   localparam int BIT_W       = 3;
   localparam int LIT_W       = 11;
   localparam int OP_W        = 4;

   // ****************************************
   // Class and opcode codes
   // ****************************************
   localparam logic [1:0] CLS_BYTE   = 2'h0;
   localparam logic [1:0] CLS_BIT    = 2'h1;
   localparam logic [1:0] CLS_BRANCH = 2'h2;
   localparam logic [1:0] CLS_LIT    = 2'h3;

   localparam logic [3:0] OP_MOVE_W  = 4'h0;
   localparam logic [3:0] OP_CLEAR   = 4'h1;
   localparam logic [3:0] OP_DEC_SKP = 4'hb;
   localparam logic [3:0] OP_INC_SKP = 4'hf;
   localparam logic [6:0] CTL_RETURN = 7'h08;
   localparam logic [6:0] CTL_RETINT = 7'h09;
   localparam logic [1:0] BIT_TEST   = 2'h2;
   localparam logic [1:0] LIT_RETW   = 2'h1;

   // ****************************************
   // Timing and reset values
   // ****************************************
   localparam int          PHASES_PER_CYCLE = 4;
   localparam logic [13:0] WORD_RESET       = 14'h0000;

   typedef enum logic [3:0]
   {
      PH_Q1 = 4'b0001,
      PH_Q2 = 4'b0010,
      PH_Q3 = 4'b0100,
      PH_Q4 = 4'b1000
   } phase_t;

   typedef struct packed
   {
      logic [1:0]  iclass;
      logic [3:0]  op;
      logic        dest;
      logic [6:0]  faddr;
      logic [2:0]  bit_idx;
      logic [10:0] lit;
      logic        lit_wide;
   } decoded_t;

endpackage : instruction_word_decode_pkg

// *** core/cycle_phase.sv ***
`timescale 1ns/1ps
module cycle_phase
(
   // Clock and reset
   input  wire logic                                clock,
   input  wire logic                                rst_n,
   input  wire logic                                clk_en,
   // Phase out
   output instruction_word_decode_pkg::phase_t      phase_r
);

   instruction_word_decode_pkg::phase_t phase_nxt;

   // ****************************************
   // Four periods per instruction cycle
   // ****************************************
   // four periods per cycle
   always_comb
   begin
      unique case (phase_r)
         instruction_word_decode_pkg::PH_Q1:
            phase_nxt = instruction_word_decode_pkg::PH_Q2;
         instruction_word_decode_pkg::PH_Q2:
            phase_nxt = instruction_word_decode_pkg::PH_Q3;
         instruction_word_decode_pkg::PH_Q3:
            phase_nxt = instruction_word_decode_pkg::PH_Q4;
         instruction_word_decode_pkg::PH_Q4:
            phase_nxt = instruction_word_decode_pkg::PH_Q1;
         default:
            phase_nxt = instruction_word_decode_pkg::PH_Q1;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         phase_r <= instruction_word_decode_pkg::PH_Q1;
      else if (clk_en)
         phase_r <= phase_nxt;
   end

endmodule : cycle_phase

// *** core/instruction_word_decode.sv ***
`timescale 1ns/1ps
// What this block does
// - Each instruction is one 14-bit word
// - Sort into byte, bit, branch, literal classes
// - Destination bit zero to W, one to file
// - File address selects source and target register
// - File address spans 0x00 to 0x7F
// - Bit index picks bit in named register
// - Literal is 8 or 11 bits wide
// - Don't-care bits never change behaviour
// - Instruction cycle lasts four clock periods
// - Taken skip or branch adds idle cycle
// - Read, modify, then store file register
// - Write-only instructions still read the register
// - Top two bits choose the class
module instruction_word_decode
(
   // Clock and reset
   input  wire logic                                clock,
   input  wire logic                                rst_n,
   input  wire logic                                clk_en,
   // Program memory fetch
   input  wire logic [13:0]                         instr_word,
   output logic                                     fetch_take_r,
   // Datapath test result, valid in the fourth period
   input  wire logic                                test_true,
   // Decoded fields and phase
   output instruction_word_decode_pkg::decoded_t    decoded_r,
   output instruction_word_decode_pkg::phase_t      phase_r,
   // File register and accumulator strobes
   output logic [6:0]                               file_addr_r,
   output logic                                     file_rd_r,
   output logic                                     file_wr_r,
   output logic                                     w_wr_r,
   // Sequencing
   output logic                                     pc_load_r,
   output logic                                     skip_r,
   output logic                                     idle_cycle_r
);

   logic [13:0]                            ir_r;
   instruction_word_decode_pkg::decoded_t  dec_nxt;
   logic                                   rd_need;
   logic                                   to_w;
   logic                                   to_f;
   logic                                   pc_chg;
   logic                                   cond;
   logic                                   extend;
   logic                                   live;

   cycle_phase u_phase
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .phase_r (phase_r)
   );

   // ****************************************
   // Word capture
   // ****************************************
   // whole word taken
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         ir_r <= instruction_word_decode_pkg::WORD_RESET;
      else if (clk_en && phase_r == instruction_word_decode_pkg::PH_Q1)
         ir_r <= instr_word;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         fetch_take_r <= 1'b0;
      else if (clk_en)
         fetch_take_r <= (phase_r == instruction_word_decode_pkg::PH_Q1);
   end

   // ****************************************
   // Field split and class decode
   // ****************************************
   always_comb
   begin
      dec_nxt.iclass   = ir_r[13:12];
      dec_nxt.op       = ir_r[11:8];
      dec_nxt.dest     = ir_r[7];
      dec_nxt.faddr    = ir_r[6:0];
      dec_nxt.bit_idx  = ir_r[9:7];
      dec_nxt.lit_wide = (ir_r[13:12] == instruction_word_decode_pkg::CLS_BRANCH);
      dec_nxt.lit      = dec_nxt.lit_wide ? ir_r[10:0]
                                          : {3'h0, ir_r[7:0]};
      rd_need = 1'b0;
      to_w    = 1'b0;
      to_f    = 1'b0;
      pc_chg  = 1'b0;
      cond    = 1'b0;
      unique case (ir_r[13:12])
         instruction_word_decode_pkg::CLS_BYTE:
         begin
            if (ir_r[11:8] == instruction_word_decode_pkg::OP_MOVE_W &&
                !ir_r[7])
            begin
               pc_chg = (ir_r[6:0] == instruction_word_decode_pkg::CTL_RETURN)
                     || (ir_r[6:0] == instruction_word_decode_pkg::CTL_RETINT);
            end
            else if (ir_r[11:8] == instruction_word_decode_pkg::OP_CLEAR &&
                     !ir_r[7])
               to_w = 1'b1;
            else
            begin
               rd_need = 1'b1;
               to_w    = !ir_r[7];
               to_f    = ir_r[7];
               cond    = (ir_r[11:8] == instruction_word_decode_pkg::OP_DEC_SKP)
                      || (ir_r[11:8] == instruction_word_decode_pkg::OP_INC_SKP);
            end
         end
         instruction_word_decode_pkg::CLS_BIT:
         begin
            rd_need = 1'b1;
            cond    = (ir_r[11:10] >= instruction_word_decode_pkg::BIT_TEST);
            to_f    = !cond;
         end
         instruction_word_decode_pkg::CLS_BRANCH:
            pc_chg = 1'b1;
         instruction_word_decode_pkg::CLS_LIT:
         begin
            to_w   = 1'b1;
            pc_chg = (ir_r[11:10] == instruction_word_decode_pkg::LIT_RETW);
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         decoded_r <= '0;
      else if (clk_en && phase_r == instruction_word_decode_pkg::PH_Q2)
         decoded_r <= dec_nxt;
   end

   // ****************************************
   // Read-modify-write strobes
   // ****************************************
   assign live = !idle_cycle_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         file_rd_r   <= 1'b0;
         file_addr_r <= 7'h00;
      end
      else if (clk_en)
      begin
         file_rd_r <= live && rd_need &&
                      phase_r == instruction_word_decode_pkg::PH_Q2;
         if (phase_r == instruction_word_decode_pkg::PH_Q2)
            file_addr_r <= ir_r[6:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         file_wr_r <= 1'b0;
         w_wr_r    <= 1'b0;
      end
      else if (clk_en)
      begin
         file_wr_r <= live && to_f &&
                      phase_r == instruction_word_decode_pkg::PH_Q4;
         w_wr_r    <= live && to_w &&
                      phase_r == instruction_word_decode_pkg::PH_Q4;
      end
   end

   // ****************************************
   // Two-cycle sequencing
   // ****************************************
   // taken skip or branch stretches
   assign extend = live && (pc_chg || (cond && test_true));

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_load_r <= 1'b0;
         skip_r    <= 1'b0;
      end
      else if (clk_en)
      begin
         pc_load_r <= live && pc_chg &&
                      phase_r == instruction_word_decode_pkg::PH_Q4;
         skip_r    <= live && cond && test_true &&
                      phase_r == instruction_word_decode_pkg::PH_Q4;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         idle_cycle_r <= 1'b0;
      else if (clk_en && phase_r == instruction_word_decode_pkg::PH_Q4)
         idle_cycle_r <= extend;
   end

   // ****************************************
   // Checks
   // ****************************************
   logic rd_seen_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rd_seen_r <= 1'b0;
      else if (clk_en && phase_r == instruction_word_decode_pkg::PH_Q1)
         rd_seen_r <= 1'b0;
      else if (file_rd_r)
         rd_seen_r <= 1'b1;
   end

   sequence s_q4_branch;
      clk_en && phase_r == instruction_word_decode_pkg::PH_Q4 &&
      !idle_cycle_r && ir_r[13:12] == instruction_word_decode_pkg::CLS_BRANCH;
   endsequence

   sequence s_pc_then_idle;
      pc_load_r && idle_cycle_r;
   endsequence

   property p_phase_onehot;
      @(posedge clock) disable iff (!rst_n)
      $onehot(phase_r);
   endproperty
   a_phase_onehot: assert property (p_phase_onehot)
      else $error("phase not one-hot");

   property p_phase_step;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && phase_r == instruction_word_decode_pkg::PH_Q4)
      |=> phase_r == instruction_word_decode_pkg::PH_Q1;
   endproperty
   a_phase_step: assert property (p_phase_step)
      else $error("phase did not wrap after fourth period");

   property p_branch_idle;
      @(posedge clock) disable iff (!rst_n)
      s_q4_branch |=> s_pc_then_idle;
   endproperty
   a_branch_idle: assert property (p_branch_idle)
      else $error("branch did not load counter and idle");

   property p_idle_quiet;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && idle_cycle_r)
      |=> !file_wr_r && !w_wr_r && !file_rd_r && !pc_load_r && !skip_r &&
          !(idle_cycle_r && phase_r == instruction_word_decode_pkg::PH_Q1);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("update during idle cycle");

   property p_read_before_write;
      @(posedge clock) disable iff (!rst_n)
      file_wr_r |-> rd_seen_r;
   endproperty
   a_read_before_write: assert property (p_read_before_write)
      else $error("file written without prior read");

   property p_write_only_reads;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && phase_r == instruction_word_decode_pkg::PH_Q2 &&
       !idle_cycle_r && ir_r[13:12] == instruction_word_decode_pkg::CLS_BYTE &&
       ir_r[7]) |=> file_rd_r;
   endproperty
   a_write_only_reads: assert property (p_write_only_reads)
      else $error("write-only instruction skipped read");

   property p_dest_w;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && phase_r == instruction_word_decode_pkg::PH_Q4 &&
       !idle_cycle_r && ir_r[13:12] == instruction_word_decode_pkg::CLS_BYTE &&
       ir_r[11:9] != 3'h0 && !ir_r[7]) |=> w_wr_r && !file_wr_r;
   endproperty
   a_dest_w: assert property (p_dest_w)
      else $error("destination zero did not go to W");

   property p_addr_field;
      @(posedge clock) disable iff (!rst_n)
      file_rd_r |-> file_addr_r == ir_r[6:0];
   endproperty
   a_addr_field: assert property (p_addr_field)
      else $error("file address differs from word");

   property p_lit_width;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && phase_r == instruction_word_decode_pkg::PH_Q2)
      |=> (decoded_r.lit_wide ? decoded_r.lit == $past(ir_r[10:0])
                              : decoded_r.lit == {3'h0, $past(ir_r[7:0])});
   endproperty
   a_lit_width: assert property (p_lit_width)
      else $error("literal width wrong");

   property p_class;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && phase_r == instruction_word_decode_pkg::PH_Q2)
      |=> decoded_r.iclass == $past(ir_r[13:12]);
   endproperty
   a_class: assert property (p_class)
      else $error("class not taken from top bits");

endmodule : instruction_word_decode

// *** testbench/prog_fetch_model.sv ***
`timescale 1ns/1ps
module prog_fetch_model
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Fetch handshake
   input  wire logic        fetch_take_r,
   output logic [13:0]      instr_word,
   // Datapath condition
   output logic             test_true
);
   // ****************************************
   // Program store and sequencing
   // ****************************************
   logic [13:0] prog [0:63];
   logic        cond [0:63];
   logic [5:0]  idx_r;

   initial
   begin
      for (int i = 0; i < 64; i++)
      begin
         prog[i] = 14'h0000;
         cond[i] = 1'b0;
      end
   end

   // Condition of the word just taken, held to its fourth period
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_r     <= 6'h00;
         test_true <= 1'b0;
      end
      else if (fetch_take_r && clk_en)
      begin
         test_true <= cond[idx_r];
         idx_r     <= idx_r + 6'h01;
      end
   end

   assign instr_word = prog[idx_r];
endmodule : prog_fetch_model

// *** testbench/instruction_word_decode_tb.sv ***
`timescale 1ns/1ps
module instruction_word_decode_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic                                  clock;
   logic                                  rst_n;
   logic                                  clk_en;
   logic [13:0]                           instr_word;
   logic                                  fetch_take_r;
   logic                                  test_true;
   instruction_word_decode_pkg::decoded_t decoded_r;
   instruction_word_decode_pkg::phase_t   phase_r;
   logic [6:0]                            file_addr_r;
   logic                                  file_rd_r;
   logic                                  file_wr_r;
   logic                                  w_wr_r;
   logic                                  pc_load_r;
   logic                                  skip_r;
   logic                                  idle_cycle_r;
   int                                    miscompares;
   int                                    checked;
   int                                    seen;

   instruction_word_decode uut
   (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .instr_word(instr_word), .fetch_take_r(fetch_take_r),
      .test_true(test_true), .decoded_r(decoded_r), .phase_r(phase_r),
      .file_addr_r(file_addr_r), .file_rd_r(file_rd_r),
      .file_wr_r(file_wr_r), .w_wr_r(w_wr_r), .pc_load_r(pc_load_r),
      .skip_r(skip_r), .idle_cycle_r(idle_cycle_r)
   );

   prog_fetch_model far_side
   (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .fetch_take_r(fetch_take_r),
      .instr_word(instr_word), .test_true(test_true)
   );

   always #2.5 clock = ~clock;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic cmp(input string nm, input logic [10:0] e,
                      input logic [10:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   // Expected strobes {rd, wr, w, pc_load, skip, idle}
   task automatic chk(input logic [5:0] e);
      int n;
      n = 0;
      while (fetch_take_r !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (fetch_take_r !== 1'b1)
      begin
         miscompares++;
         $display("unexpected fetch_take_r expected 1 seen %b", fetch_take_r);
         complete_run();
      end
      if (seen > 0)
         cmp("cycle spacing", 11'h001, 11'(n));
      @(posedge clock);
      #1;
      cmp("phase at read", 11'h004, 11'(phase_r));
      cmp("file_rd_r", 11'(e[5]), 11'(file_rd_r));
      repeat (2) @(posedge clock);
      #1;
      cmp("phase at store", 11'h001, 11'(phase_r));
      cmp("store strobes", 11'(e[4:0]), 11'({file_wr_r, w_wr_r,
          pc_load_r, skip_r, idle_cycle_r}));
      seen++;
   endtask : chk

   // Word k after the one about to run, with its test result
   task automatic put(input int k, input logic [13:0] w, input logic t);
      far_side.prog[seen + 1 + k] = w;
      far_side.cond[seen + 1 + k] = t;
   endtask : put

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values();
      repeat (20) @(posedge clock);
      #1;
      cmp("phase in reset", 11'h001, 11'(phase_r));
      cmp("strobes in reset", 11'h000, 11'({file_rd_r, file_wr_r,
          w_wr_r, pc_load_r, skip_r, idle_cycle_r, fetch_take_r}));
      cmp("fields in reset", 11'h000, 11'(|decoded_r));
      cmp("file_addr_r in reset", 11'h000, 11'(file_addr_r));
      rst_n = 1'b1;
   endtask : reset_values

   task automatic byte_ops();
      put(0, 14'h07ff, 1'b0);
      put(1, 14'h0705, 1'b0);
      put(2, 14'h0780, 1'b0);
      put(3, 14'h0190, 1'b0);
      put(4, 14'h00a0, 1'b0);
      put(5, 14'h0100, 1'b0);
      put(6, 14'h017f, 1'b0);
      put(7, 14'h0060, 1'b0);
      chk(6'h00);
      chk(6'h30);
      cmp("class", 11'h000, 11'(decoded_r.iclass));
      cmp("op", 11'h007, 11'(decoded_r.op));
      cmp("dest", 11'h001, 11'(decoded_r.dest));
      cmp("file_addr_r", 11'h07f, 11'(file_addr_r));
      chk(6'h28);
      cmp("file_addr_r", 11'h005, 11'(file_addr_r));
      chk(6'h30);
      cmp("file_addr_r", 11'h000, 11'(file_addr_r));
      chk(6'h30);
      chk(6'h30);
      chk(6'h08);
      chk(6'h08);
      chk(6'h00);
   endtask : byte_ops

   task automatic bit_ops();
      put(0, 14'h17ff, 1'b0);
      put(1, 14'h1001, 1'b0);
      put(2, 14'h1985, 1'b0);
      chk(6'h00);
      chk(6'h30);
      cmp("class", 11'h001, 11'(decoded_r.iclass));
      cmp("bit_idx", 11'h007, 11'(decoded_r.bit_idx));
      cmp("faddr", 11'h07f, 11'(decoded_r.faddr));
      chk(6'h30);
      cmp("bit_idx", 11'h000, 11'(decoded_r.bit_idx));
      chk(6'h20);
   endtask : bit_ops

   task automatic skip_ops();
      put(0, 14'h0b85, 1'b1);
      put(1, 14'h07ff, 1'b0);
      put(2, 14'h0f05, 1'b0);
      put(3, 14'h1d85, 1'b1);
      put(4, 14'h0b85, 1'b1);
      chk(6'h00);
      chk(6'h33);
      chk(6'h00);
      cmp("faddr", 11'h07f, 11'(decoded_r.faddr));
      chk(6'h28);
      chk(6'h23);
      chk(6'h00);
   endtask : skip_ops

   task automatic control_ops();
      put(0, 14'h2fff, 1'b0);
      put(1, 14'h07ff, 1'b0);
      put(2, 14'h2000, 1'b0);
      put(3, 14'h0000, 1'b0);
      put(4, 14'h0008, 1'b0);
      put(5, 14'h0000, 1'b0);
      put(6, 14'h0009, 1'b0);
      put(7, 14'h0000, 1'b0);
      put(8, 14'h34a5, 1'b0);
      put(9, 14'h0000, 1'b0);
      put(10, 14'h33ff, 1'b0);
      put(11, 14'h3e01, 1'b0);
      put(12, 14'h0063, 1'b0);
      chk(6'h00);
      chk(6'h05);
      cmp("class", 11'h002, 11'(decoded_r.iclass));
      cmp("lit", 11'h7ff, 11'(decoded_r.lit));
      cmp("lit_wide", 11'h001, 11'(decoded_r.lit_wide));
      chk(6'h00);
      for (int i = 0; i < 3; i++)
      begin
         chk(6'h05);
         chk(6'h00);
      end
      chk(6'h0d);
      cmp("class", 11'h003, 11'(decoded_r.iclass));
      cmp("lit", 11'h0a5, 11'(decoded_r.lit));
      cmp("lit_wide", 11'h000, 11'(decoded_r.lit_wide));
      chk(6'h00);
      chk(6'h08);
      cmp("lit", 11'h0ff, 11'(decoded_r.lit));
      chk(6'h08);
      chk(6'h00);
   endtask : control_ops

   // Clock enable low freezes phase and strobes
   task automatic freeze_hold();
      put(0, 14'h07ff, 1'b0);
      put(1, 14'h0705, 1'b0);
      chk(6'h00);
      chk(6'h30);
      clk_en = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      cmp("phase frozen", 11'h001, 11'(phase_r));
      cmp("file_wr_r held", 11'h001, 11'(file_wr_r));
      clk_en = 1'b1;
      chk(6'h28);
      cmp("file_addr_r", 11'h005, 11'(file_addr_r));
   endtask : freeze_hold

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      clock       = 1'b0;
      rst_n       = 1'b0;
      clk_en      = 1'b1;
      miscompares = 0;
      checked     = 0;
      seen        = 0;
      reset_values();
      byte_ops();
      bit_ops();
      skip_ops();
      control_ops();
      freeze_hold();
      complete_run();
   end
endmodule : instruction_word_decode_tb
